// >>> rtl/dzpt_defines.svh
`ifndef DZPT_DEFINES_SVH
`define DZPT_DEFINES_SVH
// ****************************************
// geometry
// ****************************************
`define DZPT_SENSOR_COLS 10'd320
`define DZPT_SENSOR_ROWS 10'd256
`define DZPT_OUT_COLS    10'd640
`define DZPT_OUT_ROWS    10'd512
`define DZPT_PIX_W       14
`define DZPT_FIFO_DEPTH  8
// ****************************************
// zoom settings and reset values
// ****************************************
`define DZPT_STEP_MAX    6'd48
`define DZPT_STEP_RST    6'd0
`define DZPT_COL_RST     10'd160
`define DZPT_ROW_RST     10'd128
`endif

// >>> rtl/dzpt_pkg.sv
`include "dzpt_defines.svh"
package dzpt_pkg;
  typedef enum logic [1:0] {DZPT_IDLE, DZPT_CAPTURE, DZPT_RENDER} dzpt_phase_e;

  typedef struct packed {
    logic                   sof;
    logic                   eol;
    logic [`DZPT_PIX_W-1:0] data;
  } dzpt_pix_s;

  typedef struct packed {
    logic [5:0] step;
    logic [9:0] col;
    logic [9:0] row;
  } dzpt_cfg_s;

  typedef struct packed {
    dzpt_phase_e phase;
    dzpt_cfg_s   pend;
    dzpt_cfg_s   act;
    logic [9:0]  ix;
    logic [9:0]  iy;
    logic [9:0]  ox;
    logic [9:0]  oy;
    logic [9:0]  sx;
    logic [9:0]  sy;
    logic [9:0]  xacc;
    logic [9:0]  yacc;
    logic [9:0]  x0;
    logic [9:0]  y0;
    logic [9:0]  ww;
    logic [9:0]  wh;
    logic        refused;
    logic        tap_valid;
    dzpt_pix_s   tap;
  } dzpt_core_s;
endpackage : dzpt_pkg

// >>> rtl/dzpt_fifo.sv
module dzpt_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } dzpt_fifo_s;

  dzpt_fifo_s       q;
  dzpt_fifo_s       next_q;
  logic [W-1:0]     mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = mem[q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction : bump

  always_comb begin
    next_q = q;
    if (push) next_q.wp = bump(q.wp);
    if (pop) next_q.rp = bump(q.rp);
    next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) q <= '0;
    else q <= next_q;
  end

  always_ff @(posedge clk) begin
    if (push) mem[q.wp] <= in_data;
  end
endmodule : dzpt_fifo

// >>> rtl/dzpt_core.sv
`include "dzpt_defines.svh"
// Contract
// - The selected window is scaled by nearest-neighbour replication to a 640x512 output frame.
// - With a 320-column sensor the window never exceeds 320x256, so upscale is at least 2.
// - Exactly 49 zoom settings, 0 through 48, are accepted.
// - Magnification is two to the power of the setting over 16, 1X to 8X.
// - The zoom setting holds 0 to 48 and resets to 0.
// - The window is centred on the array by default and may be moved to any valid centre.
// - Every requested centre is checked and one that would spill the window is refused.
// - At setting 16 the column centre is limited to 80 through 240.
// - Column centre spans 20..300 at 8X, only 160 at 1X, default 160.
// - Row centre spans 16..240 at 8X, only 128 at 1X, default 128.
// - Changing the zoom does not move overlay symbols on screen.
// - The tap ahead of the zoom is untouched by zoom and centre settings.
module dzpt_core #(
  parameter logic [9:0] SENSOR_COLS = `DZPT_SENSOR_COLS,
  parameter logic [9:0] SENSOR_ROWS = `DZPT_SENSOR_ROWS,
  parameter int         FIFO_DEPTH  = `DZPT_FIFO_DEPTH
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                s_valid,
  output logic                     s_ready,
  input  wire dzpt_pkg::dzpt_pix_s s_pix,
  output logic                     tap_valid,
  output dzpt_pkg::dzpt_pix_s      tap_pix,
  output logic                     m_valid,
  input  wire logic                m_ready,
  output dzpt_pkg::dzpt_pix_s      m_pix,
  input  wire logic                step_wr,
  input  wire logic [5:0]          magnification_step,
  input  wire logic                col_wr,
  input  wire logic [9:0]          col_in,
  input  wire logic                row_wr,
  input  wire logic [9:0]          row_in,
  output logic                     cfg_refused,
  output dzpt_pkg::dzpt_cfg_s      pend_cfg,
  output dzpt_pkg::dzpt_cfg_s      act_cfg
);
  localparam int AW = $clog2(int'(SENSOR_COLS) * int'(SENSOR_ROWS));
  localparam dzpt_pkg::dzpt_cfg_s CFG_RST = '{
    step: `DZPT_STEP_RST, col: `DZPT_COL_RST, row: `DZPT_ROW_RST};
  localparam dzpt_pkg::dzpt_core_s CORE_RST = '{
    phase: dzpt_pkg::DZPT_IDLE, pend: CFG_RST, act: CFG_RST, default: '0};

  dzpt_pkg::dzpt_core_s q;
  dzpt_pkg::dzpt_core_s next_q;
  logic [`DZPT_PIX_W-1:0] frame_mem [int'(SENSOR_COLS) * int'(SENSOR_ROWS)];
  logic                   s_fire;
  logic                   wr_en;
  logic [9:0]             wx;
  logic [9:0]             wy;
  logic                   push;
  logic                   push_ready;
  dzpt_pkg::dzpt_pix_s    push_pix;
  logic                   in_last;
  logic                   out_last;

  // ****************************************
  // window arithmetic
  // ****************************************
  // window = dim * 2^-(step/16), rounded; fraction table in Q16
  function automatic logic [9:0] win_size(input logic [9:0] dim, input logic [5:0] step);
    logic [16:0] inv;
    logic [26:0] prod;
    unique case (step[3:0])
      4'h0: inv = 17'h1_0000;
      4'h1: inv = 17'h0_F525;
      4'h2: inv = 17'h0_EAC1;
      4'h3: inv = 17'h0_E0CD;
      4'h4: inv = 17'h0_D745;
      4'h5: inv = 17'h0_CE24;
      4'h6: inv = 17'h0_C567;
      4'h7: inv = 17'h0_BD09;
      4'h8: inv = 17'h0_B505;
      4'h9: inv = 17'h0_AD58;
      4'hA: inv = 17'h0_A5FF;
      4'hB: inv = 17'h0_9EF5;
      4'hC: inv = 17'h0_9838;
      4'hD: inv = 17'h0_91C4;
      4'hE: inv = 17'h0_8B96;
      4'hF: inv = 17'h0_85AB;
    endcase
    prod = 27'(dim) * 27'(inv);
    prod = prod + (27'h000_0001 << (15 + step[5:4]));
    win_size = 10'(prod >> (16 + step[5:4]));
  endfunction : win_size

  function automatic logic [9:0] lo_bound(input logic [9:0] dim, input logic [5:0] step);
    lo_bound = win_size(dim, step) >> 1;
  endfunction : lo_bound

  function automatic logic [9:0] hi_bound(input logic [9:0] dim, input logic [5:0] step);
    hi_bound = dim - win_size(dim, step) + lo_bound(dim, step);
  endfunction : hi_bound

  function automatic logic fits(input logic [9:0] dim, input logic [5:0] step,
                                input logic [9:0] c);
    fits = (c >= lo_bound(dim, step)) && (c <= hi_bound(dim, step));
  endfunction : fits

  // keeps an existing centre legal when the window grows
  function automatic logic [9:0] clamp(input logic [9:0] dim, input logic [5:0] step,
                                       input logic [9:0] c);
    if (c < lo_bound(dim, step)) clamp = lo_bound(dim, step);
    else if (c > hi_bound(dim, step)) clamp = hi_bound(dim, step);
    else clamp = c;
  endfunction : clamp

  function automatic logic [AW-1:0] pix_addr(input logic [9:0] x, input logic [9:0] y);
    pix_addr = AW'(20'(y) * 20'(SENSOR_COLS) + 20'(x));
  endfunction : pix_addr

  // ****************************************
  // stream glue
  // ****************************************
  // input stalls while a frame renders; single frame store traded for simplicity
  assign s_ready  = (q.phase != dzpt_pkg::DZPT_RENDER);
  assign s_fire   = s_valid && s_ready;
  assign wx       = s_pix.sof ? '0 : q.ix;
  assign wy       = s_pix.sof ? '0 : q.iy;
  assign wr_en    = s_fire && (s_pix.sof || q.phase == dzpt_pkg::DZPT_CAPTURE);
  assign in_last  = (wx == SENSOR_COLS - 10'd1) && (wy == SENSOR_ROWS - 10'd1);
  assign out_last = (q.ox == `DZPT_OUT_COLS - 10'd1) && (q.oy == `DZPT_OUT_ROWS - 10'd1);
  assign push     = (q.phase == dzpt_pkg::DZPT_RENDER);

  // framing is fixed 640x512 whatever the zoom, so the overlay canvas never shifts
  always_comb begin
    push_pix.sof  = (q.ox == '0) && (q.oy == '0);
    push_pix.eol  = (q.ox == `DZPT_OUT_COLS - 10'd1);
    push_pix.data = frame_mem[pix_addr(q.x0 + q.sx, q.y0 + q.sy)];
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [10:0] xs;
    logic [10:0] ys;
    next_q = q;
    xs = 11'(q.xacc) + 11'(q.ww);
    ys = 11'(q.yacc) + 11'(q.wh);
    next_q.refused = 1'b0;
    next_q.tap_valid = s_fire;
    if (s_fire) next_q.tap = s_pix;
    if (step_wr) begin
      if (magnification_step <= `DZPT_STEP_MAX) begin
        next_q.pend.step = magnification_step;
        next_q.pend.col = clamp(SENSOR_COLS, magnification_step, q.pend.col);
        next_q.pend.row = clamp(SENSOR_ROWS, magnification_step, q.pend.row);
      end else begin
        next_q.refused = 1'b1;
      end
    end
    if (col_wr) begin
      if (fits(SENSOR_COLS, next_q.pend.step, col_in)) next_q.pend.col = col_in;
      else next_q.refused = 1'b1;
    end
    if (row_wr) begin
      if (fits(SENSOR_ROWS, next_q.pend.step, row_in)) next_q.pend.row = row_in;
      else next_q.refused = 1'b1;
    end
    unique case (q.phase)
      dzpt_pkg::DZPT_IDLE, dzpt_pkg::DZPT_CAPTURE: begin
        if (wr_en) begin
          next_q.phase = dzpt_pkg::DZPT_CAPTURE;
          next_q.ix = (wx == SENSOR_COLS - 10'd1) ? '0 : wx + 10'd1;
          next_q.iy = (wx == SENSOR_COLS - 10'd1) ? wy + 10'd1 : wy;
          if (in_last) begin
            // latch settings only between frames
            next_q.phase = dzpt_pkg::DZPT_RENDER;
            next_q.act = q.pend;
            next_q.ww = win_size(SENSOR_COLS, q.pend.step);
            next_q.wh = win_size(SENSOR_ROWS, q.pend.step);
            next_q.x0 = q.pend.col - lo_bound(SENSOR_COLS, q.pend.step);
            next_q.y0 = q.pend.row - lo_bound(SENSOR_ROWS, q.pend.step);
            next_q.ox = '0;
            next_q.oy = '0;
            next_q.sx = '0;
            next_q.sy = '0;
            next_q.xacc = '0;
            next_q.yacc = '0;
          end
        end
      end
      dzpt_pkg::DZPT_RENDER: begin
        // nearest-neighbour step: source advances when ox*w crosses a 640 boundary
        if (push_ready) begin
          if (q.ox == `DZPT_OUT_COLS - 10'd1) begin
            next_q.ox = '0;
            next_q.sx = '0;
            next_q.xacc = '0;
            next_q.oy = q.oy + 10'd1;
            if (ys >= 11'(`DZPT_OUT_ROWS)) begin
              next_q.yacc = 10'(ys - 11'(`DZPT_OUT_ROWS));
              next_q.sy = q.sy + 10'd1;
            end else begin
              next_q.yacc = 10'(ys);
            end
          end else begin
            next_q.ox = q.ox + 10'd1;
            if (xs >= 11'(`DZPT_OUT_COLS)) begin
              next_q.xacc = 10'(xs - 11'(`DZPT_OUT_COLS));
              next_q.sx = q.sx + 10'd1;
            end else begin
              next_q.xacc = 10'(xs);
            end
          end
          if (out_last) next_q.phase = dzpt_pkg::DZPT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) q <= CORE_RST;
    else q <= next_q;
  end

  always_ff @(posedge clk) begin
    if (wr_en) frame_mem[pix_addr(wx, wy)] <= s_pix.data;
  end

  dzpt_fifo #(
    .W     ($bits(dzpt_pkg::dzpt_pix_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_out_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_ready  (push_ready),
    .in_data   (push_pix),
    .out_valid (m_valid),
    .out_ready (m_ready),
    .out_data  (m_pix)
  );

  assign tap_valid   = q.tap_valid;
  assign tap_pix     = q.tap;
  assign cfg_refused = q.refused;
  assign pend_cfg    = q.pend;
  assign act_cfg     = q.act;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_line_end;
    push && push_ready && push_pix.eol |-> q.ox == `DZPT_OUT_COLS - 10'd1;
  endproperty
  a_line_end: assert property (p_line_end) else $error("eol off last column");

  property p_frame_end;
    push && push_ready && out_last |=> q.phase == dzpt_pkg::DZPT_IDLE && !push;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame not ended");

  property p_upscale;
    push |-> q.ww <= SENSOR_COLS && q.wh <= SENSOR_ROWS
             && 11'(q.ww) * 11'd2 <= 11'(`DZPT_OUT_COLS);
  endproperty
  a_upscale: assert property (p_upscale) else $error("window too large");

  property p_step_refused;
    step_wr && magnification_step > `DZPT_STEP_MAX
      |=> cfg_refused && pend_cfg.step == $past(pend_cfg.step);
  endproperty
  a_step_refused: assert property (p_step_refused) else $error("bad step taken");

  property p_mag;
    push |-> (q.act.step != 6'd16 || q.ww == SENSOR_COLS >> 1)
             && (q.act.step != 6'd48 || q.ww == SENSOR_COLS >> 3)
             && (q.act.step != 6'd0 || q.ww == SENSOR_COLS);
  endproperty
  a_mag: assert property (p_mag) else $error("window size wrong");

  property p_step_max;
    pend_cfg.step <= `DZPT_STEP_MAX;
  endproperty
  a_step_max: assert property (p_step_max) else $error("step out of range");

  property p_col_refused;
    col_wr && !step_wr && !fits(SENSOR_COLS, pend_cfg.step, col_in)
      |=> cfg_refused && $stable(pend_cfg.col);
  endproperty
  a_col_refused: assert property (p_col_refused) else $error("bad column taken");

  property p_col_at_2x;
    pend_cfg.step == 6'd16 |-> pend_cfg.col >= 10'h050 && pend_cfg.col <= 10'h0F0;
  endproperty
  a_col_at_2x: assert property (p_col_at_2x) else $error("column out of 2x span");

  property p_col_span;
    fits(SENSOR_COLS, pend_cfg.step, pend_cfg.col);
  endproperty
  a_col_span: assert property (p_col_span) else $error("column outside window span");

  property p_row_span;
    fits(SENSOR_ROWS, pend_cfg.step, pend_cfg.row);
  endproperty
  a_row_span: assert property (p_row_span) else $error("row outside window span");

  property p_tap;
    s_fire |=> tap_valid && tap_pix == $past(s_pix);
  endproperty
  a_tap: assert property (p_tap) else $error("tap altered");

  property p_apply;
    act_cfg != $past(act_cfg) |-> $past(q.phase) != dzpt_pkg::DZPT_RENDER
                                  && q.phase == dzpt_pkg::DZPT_RENDER && q.ox == '0;
  endproperty
  a_apply: assert property (p_apply) else $error("settings changed mid frame");

  property p_act_steady;
    q.phase == dzpt_pkg::DZPT_RENDER |=> $stable(act_cfg);
  endproperty
  a_act_steady: assert property (p_act_steady) else $error("settings moved in render");

  // every frame opens at the fixed canvas origin, so overlays stay put
  property p_canvas_origin;
    $rose(push) |-> push_pix.sof && q.ox == '0 && q.oy == '0;
  endproperty
  a_canvas_origin: assert property (p_canvas_origin) else $error("frame not at origin");

  property p_window_inside;
    push |-> 11'(q.x0) + 11'(q.ww) <= 11'(SENSOR_COLS)
             && 11'(q.y0) + 11'(q.wh) <= 11'(SENSOR_ROWS);
  endproperty
  a_window_inside: assert property (p_window_inside) else $error("window spills");

  property p_source_inside;
    push |-> q.sx < q.ww && q.sy < q.wh;
  endproperty
  a_source_inside: assert property (p_source_inside) else $error("source off window");

  c_full_zoom: cover property (push && q.act.step == `DZPT_STEP_MAX && out_last);
  c_refused: cover property (cfg_refused);
  c_stall: cover property (push && !push_ready);
  c_frame_done: cover property (push && push_ready && out_last);
  c_panned: cover property ($rose(push) && q.x0 != '0 && q.y0 != '0);
endmodule : dzpt_core

// >>> verif/dzpt_far_end.sv
// ****************************************
// upstream frame source and downstream sink
// ****************************************
module dzpt_far_end (
  input  wire logic           clk,
  input  wire logic           arst_n,
  input  wire logic           start,
  input  wire logic           hold,
  output logic                s_valid,
  input  wire logic           s_ready,
  output dzpt_pkg::dzpt_pix_s s_pix,
  input  wire logic           m_valid,
  output logic                m_ready,
  output logic                busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0]  x;
  logic [9:0]  y;
  logic        gap;
  logic [2:0]  cnt;
  logic [13:0] val;

  assign val     = {y[6:0], x[6:0]};
  assign s_valid = busy && !gap;
  // idle data line shows the inverse so a stale value never looks valid
  assign s_pix   = {s_valid && x == 10'h000 && y == 10'h000, x == 10'h13f,
                    s_valid ? val : ~val};
  // half-rate sink so the output buffer fills and render stalls
  assign m_ready = !hold && cnt[1];

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      x    <= 10'h000;
      y    <= 10'h000;
      gap  <= 1'b0;
      cnt  <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
      gap <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
      end else if (s_valid && s_ready) begin
        // a bubble every 32 pixels, as a real pipeline may leave
        gap <= (x[4:0] == 5'h1f);
        x   <= (x == 10'h13f) ? 10'h000 : x + 10'h001;
        if (x == 10'h13f) begin
          y <= y + 10'h001;
          if (y == 10'h0ff) begin
            busy <= 1'b0;
            y    <= 10'h000;
          end
        end
      end
    end
  end
endmodule : dzpt_far_end

// >>> verif/tb_digital_zoom_pan_tilt.sv
module tb_digital_zoom_pan_tilt;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NPOP = 1920;
  logic                clk;
  logic                arst_n;
  logic                s_valid;
  logic                s_ready;
  logic                tap_valid;
  logic                m_valid;
  logic                m_ready;
  logic                step_wr;
  logic                col_wr;
  logic                row_wr;
  logic                cfg_refused;
  logic                start;
  logic                hold;
  logic                busy;
  logic [5:0]          step_val;
  logic [9:0]          col_val;
  logic [9:0]          row_val;
  dzpt_pkg::dzpt_pix_s s_pix;
  dzpt_pkg::dzpt_pix_s tap_pix;
  dzpt_pkg::dzpt_pix_s m_pix;
  dzpt_pkg::dzpt_cfg_s pend_cfg;
  dzpt_pkg::dzpt_cfg_s act_cfg;
  dzpt_pkg::dzpt_cfg_s exp_cfg;
  dzpt_pkg::dzpt_cfg_s dflt;
  int                  err_count;
  int                  check_count;
  int                  tap_n;
  int                  pop_n;
  // step, column low/high, row low/high
  logic [9:0]          tbl [5][5] = '{
    '{10'h000, 10'h0a0, 10'h0a0, 10'h080, 10'h080},
    '{10'h008, 10'h071, 10'h0cf, 10'h05a, 10'h0a5},
    '{10'h010, 10'h050, 10'h0f0, 10'h040, 10'h0c0},
    '{10'h020, 10'h028, 10'h118, 10'h020, 10'h0e0},
    '{10'h030, 10'h014, 10'h12c, 10'h010, 10'h0f0}};

  dzpt_core u_dut (
    .clk(clk), .arst_n(arst_n), .s_valid(s_valid), .s_ready(s_ready), .s_pix(s_pix),
    .tap_valid(tap_valid), .tap_pix(tap_pix), .m_valid(m_valid), .m_ready(m_ready),
    .m_pix(m_pix), .step_wr(step_wr), .magnification_step(step_val), .col_wr(col_wr),
    .col_in(col_val), .row_wr(row_wr), .row_in(row_val), .cfg_refused(cfg_refused),
    .pend_cfg(pend_cfg), .act_cfg(act_cfg)
  );

  dzpt_far_end u_far (
    .clk(clk), .arst_n(arst_n), .start(start), .hold(hold), .s_valid(s_valid),
    .s_ready(s_ready), .s_pix(s_pix), .m_valid(m_valid), .m_ready(m_ready), .busy(busy)
  );

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // which: 0 step, 1 column, 2 row
  task automatic wr(input int which, input logic [9:0] val, input logic exp_ref);
    @(posedge clk);
    step_wr  <= (which == 0);
    col_wr   <= (which == 1);
    row_wr   <= (which == 2);
    step_val <= val[5:0];
    col_val  <= val;
    row_val  <= val;
    @(posedge clk);
    step_wr <= 1'b0;
    col_wr  <= 1'b0;
    row_wr  <= 1'b0;
    #1;
    if (!exp_ref && which == 0) exp_cfg.step = val[5:0];
    if (!exp_ref && which == 1) exp_cfg.col = val;
    if (!exp_ref && which == 2) exp_cfg.row = val;
    chk("cfg_refused", 32'(cfg_refused), 32'(exp_ref));
    chk("pend_cfg", 32'(pend_cfg), 32'(exp_cfg));
  endtask : wr

  // ****************************************
  // stream monitors
  // ****************************************
  always @(posedge clk) begin
    if (arst_n && tap_valid) begin
      chk("tap_pix", 32'(tap_pix), 32'({tap_n == 0, tap_n % 320 == 319,
          7'(tap_n / 320), 7'(tap_n % 320)}));
      tap_n++;
    end
  end

  // window origin is (20,6) at step 16 with centre (100,70)
  always @(posedge clk) begin
    if (arst_n && m_valid && m_ready && pop_n < NPOP) begin
      chk("m_pix", 32'(m_pix), 32'({pop_n == 0, pop_n % 640 == 639,
          7'(6 + pop_n / 2560), 7'(20 + (pop_n % 640) / 4)}));
      pop_n++;
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    // clean run is about 89k cycles
    #990_000;
    err_count++;
    end_sim();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    arst_n   = 1'b0;
    step_wr  = 1'b0;
    col_wr   = 1'b0;
    row_wr   = 1'b0;
    step_val = 6'h00;
    col_val  = 10'h000;
    row_val  = 10'h000;
    start    = 1'b0;
    hold     = 1'b0;
    dflt     = '{6'h00, 10'h0a0, 10'h080};
    exp_cfg  = dflt;
    repeat (11) @(posedge clk);
    #1;
    chk("pend_rst", 32'(pend_cfg), 32'(dflt));
    chk("act_rst", 32'(act_cfg), 32'(dflt));
    @(posedge clk);
    arst_n <= 1'b1;
    for (int s = 0; s <= 48; s++) wr(0, 10'(s), 1'b0);
    wr(0, 10'h031, 1'b1);
    wr(0, 10'h03f, 1'b1);
    for (int i = 0; i < 5; i++) begin
      wr(0, tbl[i][0], 1'b0);
      for (int k = 0; k < 2; k++) begin
        wr(k + 1, tbl[i][2 * k + 1] - 10'h001, 1'b1);
        wr(k + 1, tbl[i][2 * k + 1], 1'b0);
        wr(k + 1, tbl[i][2 * k + 2], 1'b0);
        wr(k + 1, tbl[i][2 * k + 2] + 10'h001, 1'b1);
      end
    end
    // narrowing the zoom pulls the centres back inside
    exp_cfg.col = 10'h0f0;
    exp_cfg.row = 10'h0c0;
    wr(0, 10'h010, 1'b0);
    wr(1, 10'h064, 1'b0);
    wr(2, 10'h046, 1'b0);
    chk("act_before", 32'(act_cfg), 32'(dflt));
    hold <= 1'b1;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (1000) @(posedge clk);
    #1;
    chk("act_mid", 32'(act_cfg), 32'(dflt));
    for (int i = 0; i < 100000 && s_ready; i++) @(posedge clk);
    #1;
    chk("act_after", 32'(act_cfg), 32'(exp_cfg));
    chk("tap_count", 32'(tap_n), 32'h0001_4000);
    repeat (40) @(posedge clk);
    #1;
    chk("m_valid_held", 32'(m_valid), 32'h0000_0001);
    hold <= 1'b0;
    for (int i = 0; i < 10000 && pop_n < NPOP; i++) @(posedge clk);
    #1;
    chk("pop_count", 32'(pop_n), 32'(NPOP));
    chk("s_ready_render", 32'(s_ready), 32'h0000_0000);
    end_sim();
  end
endmodule : tb_digital_zoom_pan_tilt
